// file: rf_frontend_pkg.sv
// Purpose: Shared constants and types for the radio front-end control block.
// Assumes: 8-bit registers with a 7-bit address, reached over the serial slave port.
// Notes: Power figures are carried in tenths of a dBm.
package rf_frontend_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_AMP_CFG = 7'h09;
    localparam logic [6:0] ADDR_CUR_LIMIT = 7'h0B;
    localparam logic [6:0] ADDR_RX_STATUS = 7'h0C;
    localparam logic [6:0] ADDR_STR_CFG = 7'h0E;
    localparam logic [6:0] ADDR_STR_DETECT = 7'h10;
    localparam logic [6:0] ADDR_STR_VALUE = 7'h11;
    localparam logic [6:0] ADDR_BOOST_TRIM = 7'h4D;
    localparam logic [6:0] ADDR_GAIN_THR1 = 7'h61;
    // ------------------------------------------------------------
    // Reset values and special codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_AMP_CFG = 8'h4F;
    localparam logic [4:0] RST_CUR_LIMIT = 5'h0B;
    localparam logic [7:0] RST_STR_CFG = 8'h02;
    localparam logic [7:0] RST_STR_DETECT = 8'hE4;
    localparam logic [7:0] RST_BOOST_TRIM = 8'h84;
    localparam logic [7:0] BOOST_TRIM_HIGH = 8'h87;
    localparam logic [7:0] RST_GAIN_THR [5] = '{8'h20, 8'h40, 8'h60, 8'h80, 8'hA0};
    // ------------------------------------------------------------
    // Power and current arithmetic, tenths of dBm and mA
    // ------------------------------------------------------------
    localparam int BOOST_PEAK_NORMAL = 170;
    localparam int BOOST_PEAK_HIGH = 200;
    localparam int BAND_PEAK_BASE = 108;
    localparam int BAND_PEAK_STEP = 6;
    localparam int LEVEL_TOP = 15;
    localparam int DB_STEP = 10;
    localparam int CUR_LOW_BASE = 45;
    localparam int CUR_LOW_STEP = 5;
    localparam int CUR_HIGH_BASE = -30;
    localparam int CUR_HIGH_STEP = 10;
    localparam int CUR_LOW_LAST = 15;
    localparam int CUR_HIGH_LAST = 27;
    localparam int CUR_CLAMP = 240;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic route;
        logic [2:0] ceiling;
        logic [3:0] level;
    } amp_cfg_t;
    typedef struct packed {
        logic [4:0] offset;
        logic [2:0] avg_code;
    } str_cfg_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_ENABLED = 2'b01,
        RX_ACTIVE = 2'b10
    } rx_state_t;
endpackage

// file: rf_frontend_control.sv
// Purpose: Amplifier routing, power and current limit, gain steps, receive states
//          and averaged signal strength for a sub-GHz radio front end.
// Assumes: Serial pins are asynchronous; all other inputs share CLK.
// Notes: Registers are 8 bits wide and reached over a mode-0 serial slave.
//
// How it works
// - Route 1: boost pin, 17-(15-level) dBm
// - Route 0: band amp, peak 10.8+0.6*ceiling
// - Trim 0x87 at 0x4D raises boost peak
// - Current limit from trim, clamped at 240
// - Receive entry waits in enabled state
// - Preamble or strength detection enters active
// - Gain codes 001, 010, 011 below thresholds
// - Gain codes 100, 110, 111 above thresholds
// - Strength equals averaged level plus offset
// - Offset signed, -16 to +15 dB
// - Average over 2^(code+1) samples
// - Calibration start restarts strength measurement
// - Registers via mode-0 serial slave only
`timescale 1ns/10ps
`default_nettype none
module rf_frontend_control (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic SER_NSEL_N,
    input wire logic SER_SCK,
    input wire logic SER_MOSI,
    output logic SER_MISO,
    output logic SER_MISO_OE,
    input wire logic HIGH_BAND,
    input wire logic RX_MODE,
    input wire logic PREAMBLE_VALID,
    input wire logic CAL_START,
    input wire logic [7:0] INPUT_LEVEL,
    input wire logic STR_SAMPLE_VALID,
    input wire logic [7:0] STR_SAMPLE,
    output logic BOOST_AMP_EN,
    output logic LOW_BAND_AMP_EN,
    output logic HIGH_BAND_AMP_EN,
    output logic signed [9:0] POWER_DBM_X10,
    output logic [7:0] CURRENT_LIMIT_MA,
    output logic [2:0] FRONT_GAIN_CODE,
    output logic RX_ENABLED_ST,
    output logic RX_ACTIVE_ST,
    output logic [7:0] SIGNAL_STRENGTH
);
    import rf_frontend_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync_a, sync_b;
    logic sck_d;
    // Second stage is the only reader of the first; sck_d gives edges.
    // Reset to the idle pin levels, so no false select or clock edge follows reset.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sync_a <= 3'b100;
            sync_b <= 3'b100;
            sck_d <= 1'b0;
        end else if (CE) begin
            sync_a <= {SER_NSEL_N, SER_SCK, SER_MOSI};
            sync_b <= sync_a;
            sck_d <= sync_b[1];
        end
    end
    logic nsel_n_s, sck_s, mosi_s, sck_rise, sck_fall;
    assign nsel_n_s = sync_b[2];
    assign sck_s = sync_b[1];
    assign mosi_s = sync_b[0];
    assign sck_rise = sck_s & ~sck_d;
    assign sck_fall = ~sck_s & sck_d;

    // ------------------------------------------------------------
    // Serial slave and register file
    // ------------------------------------------------------------
    logic [7:0] rx_sh, tx_sh, next_rx_sh, next_tx_sh;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic addr_phase, next_addr_phase, wnr, next_wnr, miso, next_miso;
    logic [6:0] addr, next_addr;
    amp_cfg_t amp_cfg, next_amp_cfg;
    str_cfg_t str_cfg, next_str_cfg;
    logic [4:0] cur_trim, next_cur_trim;
    logic [7:0] boost_trim, next_boost_trim, det_thr, next_det_thr;
    logic [7:0] gain_thr [5];
    logic [7:0] next_gain_thr [5];
    logic [7:0] str_value;
    logic [2:0] gain_code;
    rx_state_t rx_state;

    function automatic logic [7:0] read_reg(input logic [6:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == ADDR_AMP_CFG) d = amp_cfg;
        if (a == ADDR_CUR_LIMIT) d = {3'b000, cur_trim};
        if (a == ADDR_RX_STATUS) d = {3'b000, rx_state, gain_code};
        if (a == ADDR_STR_CFG) d = str_cfg;
        if (a == ADDR_STR_DETECT) d = det_thr;
        if (a == ADDR_STR_VALUE) d = str_value;
        if (a == ADDR_BOOST_TRIM) d = boost_trim;
        for (int i = 0; i < 5; i++) begin
            if (a == ADDR_GAIN_THR1 + 7'(i)) d = gain_thr[i];
        end
        return d;
    endfunction

    // Burst access: address steps after each data byte; the byte shifted out
    // during a write is the register's old value, as it was loaded beforehand.
    always_comb begin
        logic [7:0] sh;
        sh = {rx_sh[6:0], mosi_s};
        next_rx_sh = rx_sh;
        next_tx_sh = tx_sh;
        next_bit_cnt = bit_cnt;
        next_addr_phase = addr_phase;
        next_wnr = wnr;
        next_addr = addr;
        next_miso = miso;
        next_amp_cfg = amp_cfg;
        next_str_cfg = str_cfg;
        next_cur_trim = cur_trim;
        next_boost_trim = boost_trim;
        next_det_thr = det_thr;
        next_gain_thr = gain_thr;
        if (nsel_n_s) begin
            next_addr_phase = 1'b1;
            next_bit_cnt = 3'd0;
            next_tx_sh = 8'h00;
        end else if (sck_rise) begin
            next_rx_sh = sh;
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
                if (addr_phase) begin
                    next_addr_phase = 1'b0;
                    next_wnr = sh[7];
                    next_addr = sh[6:0];
                    next_tx_sh = read_reg(sh[6:0]);
                end else begin
                    if (wnr) begin
                        if (addr == ADDR_AMP_CFG) next_amp_cfg = sh;
                        if (addr == ADDR_CUR_LIMIT) next_cur_trim = sh[4:0];
                        if (addr == ADDR_STR_CFG) next_str_cfg = sh;
                        if (addr == ADDR_STR_DETECT) next_det_thr = sh;
                        if (addr == ADDR_BOOST_TRIM) next_boost_trim = sh;
                        for (int i = 0; i < 5; i++) begin
                            if (addr == ADDR_GAIN_THR1 + 7'(i)) next_gain_thr[i] = sh;
                        end
                    end
                    next_addr = addr + 7'd1;
                    next_tx_sh = read_reg(addr + 7'd1);
                end
            end
        end else if (sck_fall) begin
            next_miso = tx_sh[7];
            next_tx_sh = {tx_sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rx_sh <= 8'h00;
            tx_sh <= 8'h00;
            bit_cnt <= 3'd0;
            addr_phase <= 1'b1;
            wnr <= 1'b0;
            addr <= 7'h00;
            miso <= 1'b0;
            amp_cfg <= RST_AMP_CFG;
            str_cfg <= RST_STR_CFG;
            cur_trim <= RST_CUR_LIMIT;
            boost_trim <= RST_BOOST_TRIM;
            det_thr <= RST_STR_DETECT;
            gain_thr <= RST_GAIN_THR;
        end else if (CE) begin
            rx_sh <= next_rx_sh;
            tx_sh <= next_tx_sh;
            bit_cnt <= next_bit_cnt;
            addr_phase <= next_addr_phase;
            wnr <= next_wnr;
            addr <= next_addr;
            miso <= next_miso;
            amp_cfg <= next_amp_cfg;
            str_cfg <= next_str_cfg;
            cur_trim <= next_cur_trim;
            boost_trim <= next_boost_trim;
            det_thr <= next_det_thr;
            gain_thr <= next_gain_thr;
        end
    end

    // ------------------------------------------------------------
    // Strength averaging over a sliding window
    // ------------------------------------------------------------
    logic [7:0] samples [256];
    logic [7:0] wptr, next_wptr, avg, next_avg;
    logic [8:0] fill, next_fill;
    logic [15:0] sum, next_sum;
    logic [2:0] last_code;
    logic avg_ready, next_avg_ready, restart;
    rx_state_t next_rx_state;

    // Any change of window length restarts, since the old sum no longer fits it.
    assign restart = CAL_START || (str_cfg.avg_code != last_code)
        || (rx_state == RX_IDLE && next_rx_state == RX_ENABLED);

    always_comb begin
        logic [8:0] n;
        logic full;
        n = 9'd2 << str_cfg.avg_code;
        full = fill >= n;
        next_wptr = wptr;
        next_fill = fill;
        next_sum = sum;
        next_avg = avg;
        next_avg_ready = avg_ready;
        if (restart) begin
            next_fill = 9'd0;
            next_sum = 16'h0000;
            next_avg_ready = 1'b0;
        end else if (STR_SAMPLE_VALID) begin
            next_sum = sum + 16'(STR_SAMPLE)
                - (full ? 16'(samples[8'(wptr - n[7:0])]) : 16'h0000);
            next_fill = full ? fill : fill + 9'd1;
            next_wptr = wptr + 8'd1;
            if (next_fill >= n) begin
                next_avg = 8'(next_sum >> ({1'b0, str_cfg.avg_code} + 4'd1));
                next_avg_ready = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (CE && STR_SAMPLE_VALID) begin
            samples[wptr] <= STR_SAMPLE;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wptr <= 8'h00;
            fill <= 9'd0;
            sum <= 16'h0000;
            avg <= 8'h00;
            avg_ready <= 1'b0;
            last_code <= RST_STR_CFG[2:0];
        end else if (CE) begin
            wptr <= next_wptr;
            fill <= next_fill;
            sum <= next_sum;
            avg <= next_avg;
            avg_ready <= next_avg_ready;
            last_code <= str_cfg.avg_code;
        end
    end

    // ------------------------------------------------------------
    // Receive states
    // ------------------------------------------------------------
    // Smaller strength value means a stronger signal, so detection is at or below.
    // The fresh value is compared, since the register lags the ready flag by a cycle.
    logic [7:0] next_str_value;
    always_comb begin
        next_rx_state = rx_state;
        unique case (rx_state)
            RX_IDLE: begin
                if (RX_MODE) next_rx_state = RX_ENABLED;
            end
            RX_ENABLED: begin
                if (!RX_MODE) next_rx_state = RX_IDLE;
                else if (PREAMBLE_VALID || (avg_ready && next_str_value <= det_thr)) begin
                    next_rx_state = RX_ACTIVE;
                end
            end
            RX_ACTIVE: begin
                if (!RX_MODE) next_rx_state = RX_IDLE;
            end
            default: next_rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) rx_state <= RX_IDLE;
        else if (CE) rx_state <= next_rx_state;
    end

    // ------------------------------------------------------------
    // Derived values and registered outputs
    // ------------------------------------------------------------
    logic signed [10:0] peak, pout, strength;
    logic [7:0] cur_ma;
    always_comb begin
        if (amp_cfg.route) begin
            peak = (boost_trim == BOOST_TRIM_HIGH) ? 11'(BOOST_PEAK_HIGH)
                : 11'(BOOST_PEAK_NORMAL);
        end else begin
            peak = 11'(BAND_PEAK_BASE + BAND_PEAK_STEP * int'(amp_cfg.ceiling));
        end
        pout = peak - 11'(DB_STEP * (LEVEL_TOP - int'(amp_cfg.level)));
        if (cur_trim <= 5'(CUR_LOW_LAST)) begin
            cur_ma = 8'(CUR_LOW_BASE + CUR_LOW_STEP * int'(cur_trim));
        end else if (cur_trim <= 5'(CUR_HIGH_LAST)) begin
            cur_ma = 8'(CUR_HIGH_BASE + CUR_HIGH_STEP * int'(cur_trim));
        end else begin
            cur_ma = 8'(CUR_CLAMP);
        end
        if (INPUT_LEVEL <= gain_thr[0]) gain_code = 3'b001;
        else if (INPUT_LEVEL <= gain_thr[1]) gain_code = 3'b010;
        else if (INPUT_LEVEL <= gain_thr[2]) gain_code = 3'b011;
        else if (INPUT_LEVEL <= gain_thr[3]) gain_code = 3'b100;
        else if (INPUT_LEVEL <= gain_thr[4]) gain_code = 3'b110;
        else gain_code = 3'b111;
        // Offset is in whole dB, the value in half dB, hence the doubling.
        strength = $signed({3'b000, avg}) + ($signed(str_cfg.offset) * 11'sd2);
        if (strength < 0) next_str_value = 8'h00;
        else if (strength > 11'sd255) next_str_value = 8'hFF;
        else next_str_value = strength[7:0];
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SER_MISO <= 1'b0;
            SER_MISO_OE <= 1'b0;
            BOOST_AMP_EN <= 1'b0;
            LOW_BAND_AMP_EN <= 1'b0;
            HIGH_BAND_AMP_EN <= 1'b0;
            POWER_DBM_X10 <= 10'sd0;
            CURRENT_LIMIT_MA <= 8'h00;
            FRONT_GAIN_CODE <= 3'b001;
            RX_ENABLED_ST <= 1'b0;
            RX_ACTIVE_ST <= 1'b0;
            str_value <= 8'h00;
            SIGNAL_STRENGTH <= 8'h00;
        end else if (CE) begin
            SER_MISO <= next_miso;
            SER_MISO_OE <= ~nsel_n_s;
            BOOST_AMP_EN <= amp_cfg.route;
            LOW_BAND_AMP_EN <= ~amp_cfg.route & ~HIGH_BAND;
            HIGH_BAND_AMP_EN <= ~amp_cfg.route & HIGH_BAND;
            POWER_DBM_X10 <= pout[9:0];
            CURRENT_LIMIT_MA <= cur_ma;
            FRONT_GAIN_CODE <= gain_code;
            RX_ENABLED_ST <= (next_rx_state == RX_ENABLED);
            RX_ACTIVE_ST <= (next_rx_state == RX_ACTIVE);
            str_value <= next_str_value;
            SIGNAL_STRENGTH <= next_str_value;
        end
    end
endmodule
`default_nettype wire

// file: rf_frontend_props.sv
// Purpose: Port-level assertions for the radio front-end control block.
// Assumes: CE stays high; every output is registered on CLK.
// Notes: Bound to the design by the statement after the module.
`timescale 1ns/10ps
`default_nettype none
module rf_frontend_props (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SER_NSEL_N,
    input wire logic SER_MISO_OE,
    input wire logic HIGH_BAND,
    input wire logic RX_MODE,
    input wire logic [7:0] INPUT_LEVEL,
    input wire logic BOOST_AMP_EN,
    input wire logic LOW_BAND_AMP_EN,
    input wire logic HIGH_BAND_AMP_EN,
    input wire logic signed [9:0] POWER_DBM_X10,
    input wire logic [7:0] CURRENT_LIMIT_MA,
    input wire logic [2:0] FRONT_GAIN_CODE,
    input wire logic RX_ENABLED_ST,
    input wire logic RX_ACTIVE_ST
);
    // ----------------------------------------
    // Clocking
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Amplifier paths are exclusive, and power stays on the documented grid.
    a_one_path:
        assert property (({1'b0, BOOST_AMP_EN} + LOW_BAND_AMP_EN + HIGH_BAND_AMP_EN) <= 2'd1)
        else $error("two amplifier paths on");
    a_band_follow:
        assert property ((!BOOST_AMP_EN && (LOW_BAND_AMP_EN || HIGH_BAND_AMP_EN))
            |-> HIGH_BAND_AMP_EN == $past(HIGH_BAND)) else $error("band path mismatch");
    a_boost_power:
        assert property (BOOST_AMP_EN |-> POWER_DBM_X10 >= 20 && POWER_DBM_X10 <= 200
            && POWER_DBM_X10 % 10 == 0) else $error("boost power off grid");
    a_band_power:
        assert property ((LOW_BAND_AMP_EN || HIGH_BAND_AMP_EN) |-> POWER_DBM_X10 >= -42
            && POWER_DBM_X10 <= 150 && POWER_DBM_X10 % 2 == 0) else $error("band power off grid");
    a_current_law:
        assert property (CURRENT_LIMIT_MA <= 8'd240 && CURRENT_LIMIT_MA % 5 == 0)
        else $error("current limit off grid");
    // Gain steps: a zero level always gives the top gain; two codes never occur.
    a_gain_floor:
        assert property (INPUT_LEVEL == 8'h00 |=> FRONT_GAIN_CODE == 3'b001)
        else $error("lowest level not top gain");
    a_gain_codes:
        assert property (FRONT_GAIN_CODE != 3'b000 && FRONT_GAIN_CODE != 3'b101)
        else $error("illegal gain code");
    // Receive states.
    a_rx_entry:
        assert property ((RX_MODE && !RX_ENABLED_ST && !RX_ACTIVE_ST) |=> RX_ENABLED_ST)
        else $error("receive entry skipped enabled state");
    a_rx_states:
        assert property (!(RX_ENABLED_ST && RX_ACTIVE_ST)) else $error("two receive states");
    a_rx_active:
        assert property ($rose(RX_ACTIVE_ST) |-> $past(RX_ENABLED_ST))
        else $error("active not entered from enabled");
    a_rx_leave:
        assert property (!RX_MODE |=> !RX_ENABLED_ST && !RX_ACTIVE_ST)
        else $error("receive state held without mode");
    // Three flops of lag from the select pin to the output enable.
    a_miso_quiet:
        assert property (SER_NSEL_N [*4] |-> !SER_MISO_OE) else $error("data out driven idle");
endmodule
bind rf_frontend_control rf_frontend_props u_props (.CLK, .NRST, .SER_NSEL_N, .SER_MISO_OE,
    .HIGH_BAND, .RX_MODE, .INPUT_LEVEL, .BOOST_AMP_EN, .LOW_BAND_AMP_EN, .HIGH_BAND_AMP_EN,
    .POWER_DBM_X10, .CURRENT_LIMIT_MA, .FRONT_GAIN_CODE, .RX_ENABLED_ST, .RX_ACTIVE_ST);
`default_nettype wire

// file: rf_load_model.sv
// Purpose: Far-side model that delivers strength samples from the antenna load.
// Assumes: Samples are one-cycle pulses on the rising clock edge.
// Notes: The bus carries the inverse of the last sample between pulses.
`timescale 1ns/10ps
`default_nettype none
module rf_load_model (
    input wire logic clk,
    output logic sample_valid,
    output logic [7:0] sample
);
    initial begin
        sample_valid = 1'b0;
        sample = 8'h00;
    end
    // One sample per call; a stale value never looks valid to the receiver.
    task automatic send(input logic [7:0] v);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample <= v;
        @(posedge clk);
        sample_valid <= 1'b0;
        sample <= ~v;
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the radio front-end control block.
// Assumes: Registers reached by mode-0 serial frames with slow clock edges.
// Notes: CE is held high throughout.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
    import rf_frontend_pkg::*;
    logic clk = 0, nrst = 0, nsel_n = 1, sck = 0, mosi = 0, miso, miso_oe, high_band = 0;
    logic rx_mode = 0, preamble = 0, cal_start = 0, s_valid, boost_en, low_en, high_en;
    logic rx_en, rx_act;
    logic [7:0] in_level = 0, s_data, cur, strength, q;
    logic signed [9:0] power;
    logic [2:0] gain;
    int miscompares = 0, cmp_count = 0;
    always #50 clk = ~clk;
    rf_load_model load (.clk(clk), .sample_valid(s_valid), .sample(s_data));
    rf_frontend_control dut (.CLK(clk), .NRST(nrst), .CE(1'b1), .SER_NSEL_N(nsel_n),
        .SER_SCK(sck), .SER_MOSI(mosi), .SER_MISO(miso), .SER_MISO_OE(miso_oe),
        .HIGH_BAND(high_band), .RX_MODE(rx_mode), .PREAMBLE_VALID(preamble),
        .CAL_START(cal_start), .INPUT_LEVEL(in_level), .STR_SAMPLE_VALID(s_valid),
        .STR_SAMPLE(s_data), .BOOST_AMP_EN(boost_en), .LOW_BAND_AMP_EN(low_en),
        .HIGH_BAND_AMP_EN(high_en), .POWER_DBM_X10(power), .CURRENT_LIMIT_MA(cur),
        .FRONT_GAIN_CODE(gain), .RX_ENABLED_ST(rx_en), .RX_ACTIVE_ST(rx_act),
        .SIGNAL_STRENGTH(strength));
    // ----------------------------------------
    // Serial access; half periods of five and six clocks clear the two-flop sync.
    // ----------------------------------------
    task automatic spi(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        logic [15:0] sh;
        sh = {a, d};
        @(posedge clk) nsel_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) mosi <= sh[15 - i];
            repeat (5) @(posedge clk);
            if (i >= 8) r[15 - i] = miso;
            sck <= 1'b1;
            repeat (5) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (5) @(posedge clk);
        nsel_n <= 1'b1;
        mosi <= ~mosi;
        repeat (6) @(posedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spi({1'b1, a}, d, q);
    endtask
    task automatic rd(input logic [6:0] a);
        spi({1'b0, a}, 8'h00, q);
    endtask
    function automatic logic [9:0] pw(input int route, input int ceil, input int lvl, input int hi);
        return 10'((route ? (hi ? 200 : 170) : 108 + 6 * ceil) - 10 * (15 - lvl));
    endfunction
    function automatic logic [7:0] ma(input int c);
        return 8'(c <= 15 ? 45 + 5 * c : (c <= 27 ? 10 * c - 30 : 240));
    endfunction
    // Fills a fresh averaging window of n samples starting at v, rising by st.
    task automatic avg(input logic [7:0] cfg, input int n, input int v, input int st);
        wr(ADDR_STR_CFG, cfg);
        for (int i = 0; i < n; i++) load.send(8'(v + i * st));
        repeat (4) @(posedge clk);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        logic [2:0] codes [6];
        int cl [6];
        codes = '{3'b001, 3'b010, 3'b011, 3'b100, 3'b110, 3'b111};
        cl = '{0, 15, 16, 27, 28, 31};
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd(ADDR_BOOST_TRIM); `CHK(q, RST_BOOST_TRIM)
        rd(ADDR_AMP_CFG); `CHK(q, RST_AMP_CFG)
        `CHK(power, pw(0, 4, 15, 0))
        `CHK(cur, ma(11))
        rd(7'h7F); `CHK(q, 8'h00)
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_CUR_LIMIT, 8'(cl[i])); `CHK(cur, ma(cl[i]))
        end
        // Boost path at both trims; trim write answers with the old value.
        wr(ADDR_BOOST_TRIM, BOOST_TRIM_HIGH); `CHK(q, RST_BOOST_TRIM)
        for (int l = 0; l < 16; l += 15) begin
            wr(ADDR_AMP_CFG, 8'(8'h80 + l)); `CHK(power, pw(1, 0, l, 1))
            `CHK({boost_en, low_en, high_en}, 3'b100)
        end
        wr(ADDR_BOOST_TRIM, RST_BOOST_TRIM); `CHK(power, pw(1, 0, 15, 0))
        for (int c = 0; c < 8; c++) begin
            high_band <= c[0];
            wr(ADDR_AMP_CFG, 8'(c * 16 + 2 * c)); `CHK(power, pw(0, c, 2 * c, 0))
            `CHK({boost_en, low_en, high_en}, {1'b0, ~c[0], c[0]})
        end
        // Gain steps at each threshold and just above it.
        for (int k = 0; k < 6; k++) begin
            in_level <= (k == 0) ? 8'h00 : RST_GAIN_THR[k - 1] + 8'h01;
            repeat (3) @(posedge clk); `CHK(gain, codes[k])
            if (k < 5) begin
                in_level <= RST_GAIN_THR[k];
                repeat (3) @(posedge clk); `CHK(gain, codes[k])
            end
        end
        wr(ADDR_GAIN_THR1, 8'h05);
        in_level <= 8'h06;
        repeat (3) @(posedge clk); `CHK(gain, 3'b010)
        // Strength averaging, offset and saturation.
        avg(8'h00, 2, 100, 2); `CHK(strength, 8'd101)
        avg(8'h01, 4, 10, 10); `CHK(strength, 8'd25)
        load.send(8'd50); repeat (4) @(posedge clk); `CHK(strength, 8'd35)
        avg(8'h07, 256, 64, 0); `CHK(strength, 8'd64)
        avg(8'h78, 2, 100, 0); `CHK(strength, 8'd130)
        avg(8'h80, 2, 100, 0); `CHK(strength, 8'd68)
        avg(8'h78, 2, 250, 0); `CHK(strength, 8'd255)
        avg(8'h80, 2, 20, 0); `CHK(strength, 8'd0)
        rd(ADDR_STR_VALUE); `CHK(q, 8'h00)
        avg(8'h01, 4, 80, 0);
        @(posedge clk) cal_start <= 1'b1;
        @(posedge clk) cal_start <= 1'b0;
        for (int i = 0; i < 3; i++) load.send(8'd40);
        repeat (4) @(posedge clk); `CHK(strength, 8'd80)
        load.send(8'd40);
        repeat (4) @(posedge clk); `CHK(strength, 8'd40)
        // Receive states by strength detection, then by preamble.
        wr(ADDR_STR_CFG, 8'h00);
        rx_mode <= 1'b1;
        repeat (10) @(posedge clk); `CHK({rx_en, rx_act}, 2'b10)
        load.send(8'hF0); load.send(8'hF0);
        repeat (4) @(posedge clk); `CHK({rx_en, rx_act}, 2'b10)
        load.send(8'h10); load.send(8'h10);
        repeat (4) @(posedge clk); `CHK({rx_en, rx_act}, 2'b01)
        rx_mode <= 1'b0;
        repeat (3) @(posedge clk); `CHK({rx_en, rx_act}, 2'b00)
        rx_mode <= 1'b1;
        repeat (3) @(posedge clk) preamble <= 1'b1;
        @(posedge clk) preamble <= 1'b0;
        repeat (2) @(posedge clk); `CHK({rx_en, rx_act}, 2'b01)
        rd(ADDR_RX_STATUS); `CHK(q, 8'h12)
        rx_mode <= 1'b0;
        repeat (4) @(posedge clk);
        end_sim;
    end
    // Watchdog well beyond the expected run of about 7500 clocks.
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
